// [src/count_timer_pkg.sv]
package count_timer_pkg;
   localparam int          COUNT_WIDTH   = 16;
   localparam int          PRESCALE_DIV  = 16;
   localparam logic [15:0] COUNT_ZERO    = 16'h0000;
   localparam logic [15:0] COUNT_ONE     = 16'h0001;
   localparam logic [15:0] COUNT_ALL     = 16'hFFFF;
   // mode/source field, auxiliary_control bits 2:0
   localparam int          MODE_FIELD_W  = 3;
   localparam logic [2:0]  CNT_SRC_IN2   = 3'h0;
   localparam logic [2:0]  CNT_SRC_TXA   = 3'h1;
   localparam logic [2:0]  CNT_SRC_TXB   = 3'h2;
   localparam logic [2:0]  CNT_SRC_XT16  = 3'h3;
   localparam logic [2:0]  TMR_SRC_IN2   = 3'h4;
   localparam logic [2:0]  TMR_SRC_IN216 = 3'h5;
   localparam logic [2:0]  TMR_SRC_XT    = 3'h6;
   localparam logic [2:0]  TMR_SRC_XT16  = 3'h7;
   localparam logic [2:0]  MODE_RESET    = TMR_SRC_XT16;
   localparam int          TIMER_BIT     = 2;
endpackage : count_timer_pkg

// [src/dual_mode_count_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01: one 16-bit down counter, counter or timer
// RULE_02: reload from two bytes, 0001 to FFFF
// RULE_03: reset selects free-running timer mode; here reset only sets running, mode follows auxiliary_control
// RULE_04: counter clock from txa, txb, crystal/16, input two
// RULE_05: counter start loads reload and runs
// RULE_06: counter 0001 to 0000 sets ready
// RULE_07: counter wraps to FFFF and continues
// RULE_08: counter reload change waits for start
// RULE_09: counter stop halts and clears ready
// RULE_10: host reads count only while stopped
// RULE_11: terminal count to interrupt or output three
// RULE_12: unit output may drive output three
// RULE_13: timer clock crystal or input two, /1 or /16
// RULE_14: square wave period twice reload times source
// RULE_15: timer runs continuously, cannot be halted
// RULE_16: timer start forces output high, reloads
// RULE_17: timer terminal count inverts output, reloads
// RULE_18: timer ready on every second terminal count
// RULE_19: timer adopts reload at terminal count or start
// RULE_20: timer stop clears ready, keeps running
// RULE_21: host loads and starts before routing output
// RULE_22: three-bit mode/source field, change when idle
// RULE_23: upper byte 15:8, lower byte 7:0
module dual_mode_count_timer #(
   parameter int PRESCALE = count_timer_pkg::PRESCALE_DIV
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic [7:0] preload_upper_byte,
   input  wire logic [7:0] preload_lower_byte,
   input  wire logic [2:0] auxiliary_control,
   input  wire logic       start_cmd,
   input  wire logic       stop_cmd,
   input  wire logic       crystal_clock_input,
   input  wire logic       general_input_two,
   input  wire logic       tx_clock_a_tick,
   input  wire logic       tx_clock_b_tick,
   input  wire logic       int_enable,
   input  wire logic       route_to_output,
   input  wire logic       route_ready_to_output,
   output logic [7:0]      count_value_upper,
   output logic [7:0]      count_value_lower,
   output logic            ready_flag,
   output logic            int_n,
   output logic            general_output_three,
   output logic            square_wave,
   output logic            square_wave_tick,
   output logic            running
);
   typedef enum logic [1:0] {
      ST_STOPPED = 2'b01,
      ST_RUNNING = 2'b10
   } run_state_e;

   // two-flop synchronisers for the pin inputs
   logic [1:0] xtal_sync;
   logic [1:0] in2_sync;
   logic       xtal_prev;
   logic       in2_prev;
   logic       xtal_tick;
   logic       in2_tick;
   logic       xtal16_tick;
   logic       in216_tick;

   logic [15:0] count;
   logic [15:0] next_count;
   logic [15:0] reload;
   run_state_e  state;
   run_state_e  next_state;
   logic        next_square_wave;
   logic        next_ready_flag;
   logic        half_phase;
   logic        next_half_phase;
   logic        next_wave_tick;
   logic        src_tick;
   logic        timer_mode;
   logic        next_int_n;
   logic        next_out3;
   logic        restart_prescale;

   // reload word from byte pair
   // RULE_02: live reload, rewritable any time
   // RULE_23: byte concatenation order
   assign reload     = {preload_upper_byte, preload_lower_byte};
   assign timer_mode = auxiliary_control[count_timer_pkg::TIMER_BIT];
   assign restart_prescale = start_cmd;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         xtal_sync <= 2'b00;
         in2_sync  <= 2'b00;
         xtal_prev <= 1'b0;
         in2_prev  <= 1'b0;
      end else begin
         xtal_sync <= {xtal_sync[0], crystal_clock_input};
         in2_sync  <= {in2_sync[0], general_input_two};
         xtal_prev <= xtal_sync[1];
         in2_prev  <= in2_sync[1];
      end
   end

   // rising edges of the slow external clocks become enable pulses
   assign xtal_tick = xtal_sync[1] & ~xtal_prev;
   assign in2_tick  = in2_sync[1] & ~in2_prev;

   tick_prescaler #(.DIV(PRESCALE)) u_xtal_div (
      .clk      (clk),
      .arst_n   (arst_n),
      .tick_in  (xtal_tick),
      .restart  (restart_prescale),
      .tick_out (xtal16_tick)
   );

   tick_prescaler #(.DIV(PRESCALE)) u_in2_div (
      .clk      (clk),
      .arst_n   (arst_n),
      .tick_in  (in2_tick),
      .restart  (restart_prescale),
      .tick_out (in216_tick)
   );

   // RULE_22: source decode from mode field
   // RULE_04: counter clock sources
   // RULE_13: timer clock sources
   always_comb begin
      unique case (auxiliary_control)
         count_timer_pkg::CNT_SRC_IN2:   src_tick = in2_tick;
         count_timer_pkg::CNT_SRC_TXA:   src_tick = tx_clock_a_tick;
         count_timer_pkg::CNT_SRC_TXB:   src_tick = tx_clock_b_tick;
         count_timer_pkg::CNT_SRC_XT16:  src_tick = xtal16_tick;
         count_timer_pkg::TMR_SRC_IN2:   src_tick = in2_tick;
         count_timer_pkg::TMR_SRC_IN216: src_tick = in216_tick;
         count_timer_pkg::TMR_SRC_XT:    src_tick = xtal_tick;
         count_timer_pkg::TMR_SRC_XT16:  src_tick = xtal16_tick;
      endcase
   end

   always_comb begin
      next_state       = state;
      next_count       = count;
      next_square_wave = square_wave;
      next_half_phase  = half_phase;
      next_ready_flag  = ready_flag;
      next_wave_tick   = 1'b0;
      if (timer_mode) begin
         // RULE_15: timer never halts
         next_state = ST_RUNNING;
         // RULE_20: stop only clears ready
         if (stop_cmd) begin
            next_ready_flag = 1'b0;
         end
         if (start_cmd) begin
            // RULE_16: abort, output high, reload
            // RULE_19: start adopts new reload
            next_count       = reload;
            next_square_wave = 1'b1;
            next_half_phase  = 1'b0;
         end else if (src_tick) begin
            if (count == count_timer_pkg::COUNT_ONE) begin
               // RULE_17: invert and reload
               // RULE_14: half period equals reload
               next_count       = reload;
               next_square_wave = ~square_wave;
               next_wave_tick   = 1'b1;
               next_half_phase  = ~half_phase;
               // RULE_18: every second terminal count
               if (half_phase) begin
                  next_ready_flag = 1'b1;
               end
            end else begin
               next_count = count - 16'(1);
            end
         end
      end else begin
         // RULE_09: stop halts and clears ready
         if (stop_cmd) begin
            next_state      = ST_STOPPED;
            next_ready_flag = 1'b0;
         end
         if (start_cmd) begin
            // RULE_05: start loads reload
            // RULE_08: reload taken only here
            next_state = ST_RUNNING;
            next_count = reload;
         end else if (state == ST_RUNNING && !stop_cmd && src_tick) begin
            // RULE_07: 0000 wraps to FFFF by subtraction
            next_count = count - 16'(1);
            // RULE_06: terminal count sets ready
            if (count == count_timer_pkg::COUNT_ONE) begin
               next_ready_flag = 1'b1;
            end
         end
      end
   end

   // RULE_11: interrupt and output three
   // RULE_12: unit output onto output three
   always_comb begin
      next_int_n = ~(next_ready_flag & int_enable);
      if (route_ready_to_output) begin
         next_out3 = ~next_ready_flag;
      end else if (route_to_output) begin
         next_out3 = next_square_wave;
      end else begin
         next_out3 = 1'b1;
      end
   end

   // RULE_03: reset enters running state; timer mode only if auxiliary_control selects it
   // RULE_01: single 16-bit down counter
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state                <= ST_RUNNING;
         count                <= count_timer_pkg::COUNT_ALL;
         square_wave          <= 1'b1;
         half_phase           <= 1'b0;
         ready_flag           <= 1'b0;
         square_wave_tick     <= 1'b0;
         int_n                <= 1'b1;
         general_output_three <= 1'b1;
         count_value_upper    <= 8'h00;
         count_value_lower    <= 8'h00;
         running              <= 1'b1;
      end else begin
         state                <= next_state;
         count                <= next_count;
         square_wave          <= next_square_wave;
         half_phase           <= next_half_phase;
         ready_flag           <= next_ready_flag;
         square_wave_tick     <= next_wave_tick;
         int_n                <= next_int_n;
         general_output_three <= next_out3;
         // RULE_10: host byte views of count
         count_value_upper    <= next_count[15:8];
         count_value_lower    <= next_count[7:0];
         running              <= (next_state == ST_RUNNING);
      end
   end

   property p_start_loads;
      @(posedge clk) disable iff (!arst_n)
      start_cmd |=> (count == $past(reload));
   endproperty
   a_start_loads: assert property (p_start_loads) else $error("start did not load reload"); // RULE_05

   property p_timer_start_high;
      @(posedge clk) disable iff (!arst_n)
      (start_cmd && timer_mode) |=> square_wave;
   endproperty
   a_timer_start_high: assert property (p_timer_start_high) else $error("start not high"); // RULE_16

   property p_stop_clears;
      @(posedge clk) disable iff (!arst_n)
      (stop_cmd && !(next_wave_tick && half_phase)) |=> !ready_flag;
   endproperty
   a_stop_clears: assert property (p_stop_clears) else $error("stop kept ready"); // RULE_09

   property p_counter_stop_holds;
      @(posedge clk) disable iff (!arst_n)
      (!timer_mode && state == ST_STOPPED && !start_cmd) |=> $stable(count);
   endproperty
   a_counter_stop_holds: assert property (p_counter_stop_holds) else $error("stopped count moved"); // RULE_09

   property p_counter_wrap;
      @(posedge clk) disable iff (!arst_n)
      (!timer_mode && state == ST_RUNNING && !start_cmd && !stop_cmd && src_tick
       && count == count_timer_pkg::COUNT_ZERO) |=> count == count_timer_pkg::COUNT_ALL;
   endproperty
   a_counter_wrap: assert property (p_counter_wrap) else $error("no wrap to FFFF"); // RULE_07

   property p_counter_tc;
      @(posedge clk) disable iff (!arst_n)
      (!timer_mode && state == ST_RUNNING && !start_cmd && !stop_cmd && src_tick
       && count == count_timer_pkg::COUNT_ONE) |=> ready_flag;
   endproperty
   a_counter_tc: assert property (p_counter_tc) else $error("terminal count lost"); // RULE_06

   property p_timer_toggle;
      @(posedge clk) disable iff (!arst_n)
      (timer_mode && !start_cmd && src_tick && count == count_timer_pkg::COUNT_ONE)
      |=> (square_wave != $past(square_wave)) && count == $past(reload);
   endproperty
   a_timer_toggle: assert property (p_timer_toggle) else $error("timer no toggle"); // RULE_17

   property p_timer_running;
      @(posedge clk) disable iff (!arst_n)
      timer_mode |=> state == ST_RUNNING;
   endproperty
   a_timer_running: assert property (p_timer_running) else $error("timer halted"); // RULE_15

   property p_int_follow;
      @(posedge clk) disable iff (!arst_n)
      (next_ready_flag && int_enable) |=> !int_n;
   endproperty
   a_int_follow: assert property (p_int_follow) else $error("int not asserted"); // RULE_11
endmodule : dual_mode_count_timer
`default_nettype wire

// [src/tick_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
// divides a stream of one-cycle ticks by a fixed ratio
module tick_prescaler #(
   parameter int DIV = 16
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic tick_in,
   input  wire logic restart,
   output logic      tick_out
);
   localparam int W = $clog2(DIV);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic         next_tick_out;

   always_comb begin
      next_cnt      = cnt;
      next_tick_out = 1'b0;
      if (restart) begin
         next_cnt = '0;
      end else if (tick_in) begin
         if (cnt == W'(DIV - 1)) begin
            next_cnt      = '0;
            next_tick_out = 1'b1;
         end else begin
            next_cnt = cnt + W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt      <= '0;
         tick_out <= 1'b0;
      end else begin
         cnt      <= next_cnt;
         tick_out <= next_tick_out;
      end
   end
endmodule : tick_prescaler
`default_nettype wire

// [verification/test_dual_mode_count_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dual_mode_count_timer;
   localparam int PRE     = 2;
   localparam int PIN_PER = 8;
   logic        clk;
   logic        arst_n;
   logic [7:0]  preload_upper_byte;
   logic [7:0]  preload_lower_byte;
   logic [2:0]  auxiliary_control;
   logic        start_cmd;
   logic        stop_cmd;
   logic        crystal_clock_input;
   logic        general_input_two;
   logic        tx_clock_a_tick;
   logic        tx_clock_b_tick;
   logic        int_enable;
   logic        route_to_output;
   logic        route_ready_to_output;
   logic [7:0]  count_value_upper;
   logic [7:0]  count_value_lower;
   logic        ready_flag;
   logic        int_n;
   logic        general_output_three;
   logic        square_wave;
   logic        square_wave_tick;
   logic        running;
   logic [1:0]  phase;
   logic [15:0] r1;
   logic [15:0] r2;
   int          fails;
   int          checks;
   int          n;

   dual_mode_count_timer #(.PRESCALE(PRE)) uut (
      .clk, .arst_n, .preload_upper_byte, .preload_lower_byte, .auxiliary_control,
      .start_cmd, .stop_cmd, .crystal_clock_input, .general_input_two, .tx_clock_a_tick,
      .tx_clock_b_tick, .int_enable, .route_to_output, .route_ready_to_output,
      .count_value_upper, .count_value_lower, .ready_flag, .int_n, .general_output_three,
      .square_wave, .square_wave_tick, .running);

   always #25 clk = ~clk;

   // both pins share one slow wave, period eight clocks
   always @(posedge clk) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
         crystal_clock_input <= ~crystal_clock_input;
         general_input_two   <= ~general_input_two;
      end
   end

   function automatic int exp_period(input logic [2:0] m, input logic [15:0] r);
      return int'(r) * PIN_PER * (m[0] ? PRE : 1);
   endfunction : exp_period

   function automatic logic exp_int(input logic rdy, input logic en);
      return ~(rdy & en);
   endfunction : exp_int

   task automatic stop_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test

   task automatic chk_bit(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic chk_word(input logic [15:0] exp);
      checks++;
      if ({count_value_upper, count_value_lower} !== exp) begin
         fails++;
         $display("mismatch count expected %h seen %h", exp,
                  {count_value_upper, count_value_lower});
      end
   endtask : chk_word

   task automatic chk_period(input int exp, input int got);
      checks++;
      if (got != exp) begin
         fails++;
         $display("mismatch period expected %0d seen %0d", exp, got);
      end
   endtask : chk_period

   task automatic cmd(input logic go);
      @(posedge clk);
      start_cmd <= go;
      stop_cmd  <= ~go;
      @(posedge clk);
      start_cmd <= 1'b0;
      stop_cmd  <= 1'b0;
      #1;
   endtask : cmd

   task automatic tick_n(input logic [2:0] m, input int k);
      repeat (k) begin
         @(posedge clk);
         tx_clock_a_tick <= (m == count_timer_pkg::CNT_SRC_TXA);
         tx_clock_b_tick <= (m == count_timer_pkg::CNT_SRC_TXB);
         @(posedge clk);
         tx_clock_a_tick <= 1'b0;
         tx_clock_b_tick <= 1'b0;
      end
      #1;
   endtask : tick_n

   // bounded wait for the next toggle pulse, in clocks
   task automatic wait_tick(output int cyc);
      cyc = 0;
      do begin
         @(posedge clk);
         #1;
         cyc++;
      end while (square_wave_tick !== 1'b1 && cyc < 3000);
   endtask : wait_tick

   task automatic counter_run(input logic [2:0] m, input logic en);
      r1 = (m == count_timer_pkg::CNT_SRC_TXB) ? 16'h0001 : 16'($urandom_range(2, 40));
      r2 = 16'($urandom) | 16'h0001;
      @(posedge clk);
      auxiliary_control <= m;
      int_enable <= en;
      route_ready_to_output <= 1'b1;
      route_to_output <= 1'b0;
      {preload_upper_byte, preload_lower_byte} <= r1;
      cmd(1'b0);
      cmd(1'b1);
      chk_word(r1);
      chk_bit("running", 1'b1, running);
      @(posedge clk);
      {preload_upper_byte, preload_lower_byte} <= r2;
      tick_n(m, int'(r1) - 1);
      chk_word(count_timer_pkg::COUNT_ONE);
      chk_bit("ready", 1'b0, ready_flag);
      tick_n(m, 1);
      chk_word(count_timer_pkg::COUNT_ZERO);
      chk_bit("ready", 1'b1, ready_flag);
      chk_bit("int_n", exp_int(1'b1, en), int_n);
      chk_bit("out3", 1'b0, general_output_three);
      tick_n(m, 1);
      chk_word(count_timer_pkg::COUNT_ALL);
      cmd(1'b0);
      chk_bit("running", 1'b0, running);
      chk_bit("ready", 1'b0, ready_flag);
      chk_bit("int_n", 1'b1, int_n);
      tick_n(m, 3);
      chk_word(count_timer_pkg::COUNT_ALL);
      cmd(1'b1);
      chk_word(r2);
   endtask : counter_run

   // pin-clocked counter modes: tick phase is free, so elapsed time has a window
   task automatic counter_pin(input logic [2:0] m);
      r1 = 16'($urandom_range(2, 9));
      @(posedge clk);
      auxiliary_control <= m;
      {preload_upper_byte, preload_lower_byte} <= r1;
      cmd(1'b0);
      cmd(1'b1);
      n = 0;
      while (ready_flag !== 1'b1 && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_bit("elapsed", 1'b1,
              n > exp_period(m, r1 - 16'h0001) && n <= exp_period(m, r1) + 4);
      cmd(1'b0);
      chk_word(count_timer_pkg::COUNT_ZERO);
   endtask : counter_pin

   task automatic timer_run(input logic [2:0] m);
      r1 = 16'($urandom_range(2, 6));
      r2 = 16'($urandom_range(1, 6));
      @(posedge clk);
      auxiliary_control <= m;
      int_enable <= 1'b1;
      route_ready_to_output <= 1'b0;
      route_to_output <= 1'b0;
      {preload_upper_byte, preload_lower_byte} <= r1;
      // start before stop: a stop first leaves a gap where ready could be set
      cmd(1'b1);
      cmd(1'b0);
      chk_bit("wave", 1'b1, square_wave);
      @(posedge clk);
      {preload_upper_byte, preload_lower_byte} <= r2;
      route_to_output <= 1'b1;
      @(posedge clk);
      #1;
      chk_bit("out3", 1'b1, general_output_three);
      wait_tick(n);
      chk_bit("wave", 1'b0, square_wave);
      chk_bit("out3", 1'b0, general_output_three);
      chk_bit("ready", 1'b0, ready_flag);
      wait_tick(n);
      chk_period(exp_period(m, r2), n);
      chk_bit("ready", 1'b1, ready_flag);
      chk_bit("int_n", exp_int(1'b1, 1'b1), int_n);
      cmd(1'b0);
      chk_bit("ready", 1'b0, ready_flag);
      wait_tick(n);
      wait_tick(n);
      chk_period(exp_period(m, r2), n);
   endtask : timer_run

   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      {preload_upper_byte, preload_lower_byte} = 16'h0010;
      auxiliary_control = count_timer_pkg::MODE_RESET;
      {start_cmd, stop_cmd, tx_clock_a_tick, tx_clock_b_tick} = 4'h0;
      {crystal_clock_input, general_input_two, int_enable} = 3'h0;
      {route_to_output, route_ready_to_output} = 2'h0;
      phase = 2'h0;
      fails = 0;
      checks = 0;
      void'($urandom(32'h81EB));
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      chk_bit("running", 1'b1, running);
      chk_bit("wave", 1'b1, square_wave);
      chk_bit("ready", 1'b0, ready_flag);
      // reset count is all ones, far too long to time; restart first
      cmd(1'b1);
      wait_tick(n);
      wait_tick(n);
      chk_period(exp_period(3'h7, 16'h0010), n);
      counter_run(count_timer_pkg::CNT_SRC_TXA, 1'b1);
      counter_run(count_timer_pkg::CNT_SRC_TXB, 1'b0);
      counter_pin(count_timer_pkg::CNT_SRC_IN2);
      counter_pin(count_timer_pkg::CNT_SRC_XT16);
      for (int m = 4; m < 8; m++) begin
         timer_run(3'(m));
      end
      stop_test();
   end

   // generous bound, the full run needs a few thousand clocks
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      stop_test();
   end
endmodule : test_dual_mode_count_timer
`default_nettype wire
